// File: hdl/sfdp_pkg.sv
// Function
// - Command 5Ah reads separate parameter space
// - Header sits at byte address zero
// - Header gives revisions and table pointers
// - Bytes 00h-03h return S F D P
// - Basic parameter table starts at 0300h
// - Order: header, basic table, 4-byte table
// - 4-byte table placed after basic table
// - Parameter space is read-only
// - Revisions 06h/01h, header count 01h
// - Byte 0Bh returns basic length 10h
`default_nettype none
package sfdp_pkg;

    localparam int          ADDR_W       = 24;
    localparam int          BYTE_W       = 8;
    localparam int          BUF_DEPTH    = 2;

    localparam logic [7:0]  READ_CMD     = 8'h5a;
    localparam logic [4:0]  CMD_LAST     = 5'h07;
    localparam logic [4:0]  ADDR_LAST    = 5'h17;
    localparam logic [4:0]  DUMMY_LAST   = 5'h07;
    localparam logic [2:0]  BYTE_LAST    = 3'h7;

    localparam logic [23:0] HDR_BASE     = 24'h000000;
    localparam logic [23:0] HDR_END      = 24'h000018;
    localparam logic [23:0] BASIC_BASE   = 24'h000300;
    localparam logic [23:0] BASIC_END    = 24'h000340;
    localparam logic [23:0] FOUR_BASE    = 24'h000340;
    localparam logic [23:0] FOUR_END     = 24'h000348;

    localparam logic [7:0]  SIG_S        = 8'h53;
    localparam logic [7:0]  SIG_F        = 8'h46;
    localparam logic [7:0]  SIG_D        = 8'h44;
    localparam logic [7:0]  SIG_P        = 8'h50;
    localparam logic [7:0]  SFDP_MINOR   = 8'h06;
    localparam logic [7:0]  SFDP_MAJOR   = 8'h01;
    localparam logic [7:0]  HDR_COUNT    = 8'h01;
    localparam logic [7:0]  UNUSED_BYTE  = 8'hff;
    localparam logic [7:0]  BASIC_ID_LSB = 8'h00;
    localparam logic [7:0]  BASIC_MINOR  = 8'h06;
    localparam logic [7:0]  BASIC_MAJOR  = 8'h01;
    localparam logic [7:0]  BASIC_DWORDS = 8'h10;
    localparam logic [7:0]  FOUR_ID_LSB  = 8'h84;
    localparam logic [7:0]  FOUR_MINOR   = 8'h00;
    localparam logic [7:0]  FOUR_MAJOR   = 8'h01;
    localparam logic [7:0]  FOUR_DWORDS  = 8'h02;
    localparam logic [7:0]  ID_MSB       = 8'hff;
    localparam logic [7:0]  GAP_FILL     = 8'hff;

    // Byte n of the header sits at bits [8n+7:8n]
    // Both parameter headers are part of it, so 24 bytes in all
    localparam logic [191:0] HEADER_BITS = {
        ID_MSB, FOUR_BASE[23:16], FOUR_BASE[15:8], FOUR_BASE[7:0],
        FOUR_DWORDS, FOUR_MAJOR, FOUR_MINOR, FOUR_ID_LSB,
        ID_MSB, BASIC_BASE[23:16], BASIC_BASE[15:8], BASIC_BASE[7:0],
        BASIC_DWORDS, BASIC_MAJOR, BASIC_MINOR, BASIC_ID_LSB,
        UNUSED_BYTE, HDR_COUNT, SFDP_MAJOR, SFDP_MINOR,
        SIG_P, SIG_D, SIG_F, SIG_S};

    // Table bodies are device-specific; filled at integration
    localparam logic [511:0] BASIC_BITS  = {64{8'hff}};
    localparam logic [63:0]  FOUR_BITS   = {8{8'hff}};

    typedef struct packed {
        logic [23:0] addr;
        logic [7:0]  data;
    } rom_beat_s;

endpackage
`default_nettype wire

// File: hdl/param_lookup.sv
`timescale 1ns/100ps
`default_nettype none
module param_lookup
    import sfdp_pkg::*;
(
    input  wire logic [23:0] addr,
    output logic      [7:0]  data
);

    logic [23:0] off;

    // no write path
    // Fixed contents only: no write path reaches this space
    always_comb begin
        off  = 24'h000000;
        data = GAP_FILL;
        if (addr < HDR_END) begin
            off  = addr - HDR_BASE;
            data = HEADER_BITS[{off[4:0], 3'b000} +: 8];
        end else if (addr >= BASIC_BASE && addr < BASIC_END) begin
            off  = addr - BASIC_BASE;
            data = BASIC_BITS[{off[5:0], 3'b000} +: 8];
        end else if (addr >= FOUR_BASE && addr < FOUR_END) begin
            off  = addr - FOUR_BASE;
            data = FOUR_BITS[{off[2:0], 3'b000} +: 8];
        end
    end

endmodule
`default_nettype wire

// File: hdl/beat_buffer.sv
`timescale 1ns/100ps
`default_nettype none
module beat_buffer
    import sfdp_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire logic      rst_n,
    input  wire logic      ce,
    input  wire logic      flush,
    input  wire logic      in_valid,
    output logic           in_ready,
    input  wire rom_beat_s in_beat,
    output logic           out_valid,
    input  wire logic      out_ready,
    output rom_beat_s      out_beat
);

    typedef struct packed {
        rom_beat_s [BUF_DEPTH-1:0] slot;
        logic                      wp;
        logic                      rp;
        logic [1:0]                cnt;
    } buf_state_s;

    buf_state_s st;
    buf_state_s next_st;
    logic       push;
    logic       pop;

    assign in_ready  = (st.cnt != 2'd2) && !flush;
    assign out_valid = (st.cnt != 2'd0) && !flush;
    assign out_beat  = st.slot[st.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (flush) begin
            next_st.wp  = 1'b0;
            next_st.rp  = 1'b0;
            next_st.cnt = 2'd0;
        end else begin
            if (push) begin
                next_st.slot[st.wp] = in_beat;
                next_st.wp          = ~st.wp;
            end
            if (pop) begin
                next_st.rp = ~st.rp;
            end
            next_st.cnt = 2'(st.cnt + {1'b0, push} - {1'b0, pop});
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

endmodule
`default_nettype wire

// File: hdl/discoverable_parameter_rom.sv
`timescale 1ns/100ps
`default_nettype none
module discoverable_parameter_rom
    import sfdp_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic mosi,
    output logic      miso,
    output logic      miso_oe
);

    typedef enum {ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE} phase_e;

    typedef struct packed {
        phase_e      phase;
        logic        sclk_q;
        logic [4:0]  bit_cnt;
        logic [7:0]  cmd;
        logic [23:0] addr_sr;
        logic [23:0] fetch_addr;
        logic        fetch_on;
        logic [7:0]  out_sr;
        logic [2:0]  out_bits;
        logic        miso;
        logic        miso_oe;
    } spi_state_s;

    spi_state_s st;
    spi_state_s next_st;

    logic       rise;
    logic       fall;
    logic       flush;
    logic       fill_ready;
    logic       push;
    logic       drain_valid;
    logic       drain_ready;
    rom_beat_s  fill_beat;
    rom_beat_s  drain_beat;
    logic [7:0] rom_data;
    logic [7:0] next_cmd;

    ////////////////////////////////////////////////////////////////////////////
    // Parameter space and prefetch buffer

    param_lookup u_lookup (
        .addr (st.fetch_addr),
        .data (rom_data)
    );

    assign fill_beat = '{addr: st.fetch_addr, data: rom_data};
    assign flush     = cs_n;
    assign push      = ce && st.fetch_on && fill_ready;

    // Two beats ahead so a late fetch never starves the shifter
    beat_buffer u_buffer (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .flush     (flush),
        .in_valid  (st.fetch_on),
        .in_ready  (fill_ready),
        .in_beat   (fill_beat),
        .out_valid (drain_valid),
        .out_ready (drain_ready),
        .out_beat  (drain_beat)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Serial framing

    assign rise        = sclk && !st.sclk_q;
    assign fall        = !sclk && st.sclk_q;
    assign next_cmd    = {st.cmd[6:0], mosi};
    assign drain_ready = ce && !cs_n && fall && (st.phase == ST_DATA) && (st.out_bits == 3'h0);

    always_comb begin
        next_st        = st;
        next_st.sclk_q = sclk;
        if (cs_n) begin
            next_st.phase    = ST_IDLE;
            next_st.bit_cnt  = 5'h00;
            next_st.fetch_on = 1'b0;
            next_st.out_bits = 3'h0;
            next_st.miso     = 1'b0;
            next_st.miso_oe  = 1'b0;
        end else begin
            unique case (st.phase)
                ST_IDLE: begin
                    next_st.phase   = ST_CMD;
                    next_st.bit_cnt = 5'h00;
                    if (rise) begin
                        next_st.cmd     = next_cmd;
                        next_st.bit_cnt = 5'h01;
                    end
                end
                ST_CMD: begin
                    if (rise) begin
                        next_st.cmd     = next_cmd;
                        next_st.bit_cnt = st.bit_cnt + 5'h01;
                        if (st.bit_cnt == CMD_LAST) begin
                            next_st.bit_cnt = 5'h00;
                            next_st.phase   = (next_cmd == READ_CMD) ? ST_ADDR : ST_IGNORE;
                        end
                    end
                end
                ST_ADDR: begin
                    if (rise) begin
                        next_st.addr_sr = {st.addr_sr[22:0], mosi};
                        next_st.bit_cnt = st.bit_cnt + 5'h01;
                        if (st.bit_cnt == ADDR_LAST) begin
                            next_st.bit_cnt    = 5'h00;
                            next_st.phase      = ST_DUMMY;
                            next_st.fetch_addr = {st.addr_sr[22:0], mosi};
                            next_st.fetch_on   = 1'b1;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (rise) begin
                        next_st.bit_cnt = st.bit_cnt + 5'h01;
                        if (st.bit_cnt == DUMMY_LAST) begin
                            next_st.bit_cnt = 5'h00;
                            next_st.phase   = ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (fall) begin
                        next_st.miso_oe = 1'b1;
                        if (st.out_bits == 3'h0) begin
                            next_st.out_bits = BYTE_LAST;
                            if (drain_valid) begin
                                next_st.miso   = drain_beat.data[7];
                                next_st.out_sr = {drain_beat.data[6:0], 1'b0};
                            end else begin
                                // Starved byte reads as all ones
                                next_st.miso   = 1'b1;
                                next_st.out_sr = 8'hfe;
                            end
                        end else begin
                            next_st.out_bits = st.out_bits - 3'h1;
                            next_st.miso     = st.out_sr[7];
                            next_st.out_sr   = {st.out_sr[6:0], 1'b0};
                        end
                    end
                end
                ST_IGNORE: begin
                    next_st.phase = ST_IGNORE;
                end
            endcase
        end
        if (push) begin
            next_st.fetch_addr = st.fetch_addr + 24'h000001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st       <= '0;
            st.phase <= ST_IDLE;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign miso    = st.miso;
    assign miso_oe = st.miso_oe;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_read_cmd_only;
        @(posedge ref_clk) disable iff (!rst_n)
        st.fetch_on |-> (st.cmd == READ_CMD);
    endproperty
    a_read_cmd_only: assert property (p_read_cmd_only)
        else $error("fetch running without read command");

    property p_zero_entry;
        @(posedge ref_clk) disable iff (!rst_n)
        push && (fill_beat.addr == HDR_BASE) |-> (fill_beat.data == SIG_S);
    endproperty
    a_zero_entry: assert property (p_zero_entry)
        else $error("address zero is not the header entry");

    property p_signature;
        @(posedge ref_clk) disable iff (!rst_n)
        push && (fill_beat.addr >= 24'h000001) && (fill_beat.addr <= 24'h000003) |->
            fill_beat.data == ((fill_beat.addr == 24'h000001) ? SIG_F :
                               (fill_beat.addr == 24'h000002) ? SIG_D : SIG_P);
    endproperty
    a_signature: assert property (p_signature)
        else $error("signature byte wrong");

    property p_revisions;
        @(posedge ref_clk) disable iff (!rst_n)
        push && (fill_beat.addr >= 24'h000004) && (fill_beat.addr <= 24'h000006) |->
            fill_beat.data == ((fill_beat.addr == 24'h000004) ? SFDP_MINOR :
                               (fill_beat.addr == 24'h000005) ? SFDP_MAJOR : HDR_COUNT);
    endproperty
    a_revisions: assert property (p_revisions)
        else $error("header revision or count wrong");

    property p_basic_length;
        @(posedge ref_clk) disable iff (!rst_n)
        push && (fill_beat.addr == 24'h00000b) |-> (fill_beat.data == BASIC_DWORDS);
    endproperty
    a_basic_length: assert property (p_basic_length)
        else $error("basic table length wrong");

    property p_basic_ptr;
        @(posedge ref_clk) disable iff (!rst_n)
        push && (fill_beat.addr >= 24'h00000c) && (fill_beat.addr <= 24'h00000e) |->
            fill_beat.data == BASIC_BASE[{fill_beat.addr[1:0] - 2'd0, 3'b000} +: 8];
    endproperty
    a_basic_ptr: assert property (p_basic_ptr)
        else $error("basic table pointer wrong");

    property p_table_order;
        @(posedge ref_clk) disable iff (!rst_n)
        push && (fill_beat.addr == 24'h000015) |->
            (fill_beat.data == FOUR_BASE[15:8]) && (FOUR_BASE >= BASIC_END);
    endproperty
    a_table_order: assert property (p_table_order)
        else $error("4-byte table not after basic table");

    property p_header_fields;
        @(posedge ref_clk) disable iff (!rst_n)
        push && (fill_beat.addr == 24'h000009) |-> (fill_beat.data == BASIC_MINOR);
    endproperty
    a_header_fields: assert property (p_header_fields)
        else $error("parameter header revision wrong");

    property p_addr_step;
        @(posedge ref_clk) disable iff (!rst_n)
        push |=> (st.fetch_addr == $past(st.fetch_addr) + 24'h000001);
    endproperty
    a_addr_step: assert property (p_addr_step)
        else $error("address did not advance by one");

    property p_no_write;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.phase == ST_DATA) && ce && !cs_n && !push |=> $stable(st.fetch_addr);
    endproperty
    a_no_write: assert property (p_no_write)
        else $error("data phase input altered the space");

    property p_release;
        @(posedge ref_clk) disable iff (!rst_n)
        ce && cs_n |=> !miso_oe && !st.fetch_on;
    endproperty
    a_release: assert property (p_release)
        else $error("output still driven after deselect");

    property p_oe_in_data;
        @(posedge ref_clk) disable iff (!rst_n)
        miso_oe |-> (st.phase == ST_DATA);
    endproperty
    a_oe_in_data: assert property (p_oe_in_data)
        else $error("output enabled outside the data phase");

    property p_ignore_quiet;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.phase == ST_IGNORE) |-> !miso_oe && !st.fetch_on;
    endproperty
    a_ignore_quiet: assert property (p_ignore_quiet)
        else $error("foreign command produced output");

    property p_stall_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        ce && !cs_n && (st.phase == ST_DATA) && !fall |=> $stable(miso);
    endproperty
    a_stall_hold: assert property (p_stall_hold)
        else $error("output bit changed without a clock fall");

    property p_byte_load;
        @(posedge ref_clk) disable iff (!rst_n)
        drain_ready && drain_valid |=> miso_oe && (miso == $past(drain_beat.data[7]));
    endproperty
    a_byte_load: assert property (p_byte_load)
        else $error("byte did not start with its top bit");

    c_data_phase: cover property (@(posedge ref_clk) disable iff (!rst_n)
        drain_ready && drain_valid && (drain_beat.addr == HDR_BASE));
    c_buffer_full: cover property (@(posedge ref_clk) disable iff (!rst_n)
        st.fetch_on && !fill_ready && !cs_n);
    c_other_cmd: cover property (@(posedge ref_clk) disable iff (!rst_n)
        st.phase == ST_IGNORE);
    c_basic_read: cover property (@(posedge ref_clk) disable iff (!rst_n)
        push && (fill_beat.addr == BASIC_BASE));

endmodule
`default_nettype wire

// File: sim/spi_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
    input  wire logic ref_clk,
    output var  logic cs_n,
    output var  logic sclk,
    output var  logic mosi,
    input  wire logic miso,
    input  wire logic miso_oe
);
    logic [7:0] rx [0:31];
    logic       oe_any;
    logic       oe_all;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One mode-0 clock period; miso is taken late in the low phase, as a host does
    task automatic bit_cycle(input logic b, input int half, output logic q, output logic oe);
        @(posedge ref_clk);
        sclk <= 1'b0;
        mosi <= b;
        repeat (half) @(posedge ref_clk);
        @(negedge ref_clk);
        q  = miso;
        oe = miso_oe;
        @(posedge ref_clk);
        sclk <= 1'b1;
        repeat (half) @(posedge ref_clk);
    endtask

    // A long half period stalls the receiving side while the device prefetches
    task automatic xfer(input logic [7:0] cmd, input logic [23:0] addr,
                        input int nbytes, input int half);
        logic [39:0] head;
        logic        q;
        logic        oe;
        head   = {cmd, addr, 8'h00};
        oe_any = 1'b0;
        oe_all = 1'b1;
        @(posedge ref_clk);
        cs_n <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            bit_cycle(head[39-i], half, q, oe);
            oe_any = oe_any | (oe === 1'b1);
        end
        for (int i = 0; i < nbytes * 8; i++) begin
            // Data phase input is ignored by the device, so keep it moving
            bit_cycle(i[0], half, q, oe);
            rx[i/8] = {rx[i/8][6:0], q};
            oe_any  = oe_any | (oe === 1'b1);
            oe_all  = oe_all & (oe === 1'b1);
        end
        @(posedge ref_clk);
        sclk <= 1'b0;
        @(posedge ref_clk);
        cs_n <= 1'b1;
        mosi <= ~mosi;
    endtask
endmodule
`default_nettype wire

// File: sim/tb_discoverable_parameter_rom.sv
`timescale 1ns/100ps
`default_nettype none
module tb_discoverable_parameter_rom
    import sfdp_pkg::*;
;
    logic        ref_clk;
    logic        rst_n;
    logic        ce;
    logic        cs_n;
    logic        sclk;
    logic        mosi;
    logic        miso;
    logic        miso_oe;
    int          mismatches;
    int          n_tests;
    logic [7:0]  hdr_exp [0:23];
    logic [23:0] ptr1;
    logic [23:0] ptr2;

    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    discoverable_parameter_rom i_dut (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .cs_n    (cs_n),
        .sclk    (sclk),
        .mosi    (mosi),
        .miso    (miso),
        .miso_oe (miso_oe)
    );

    spi_host_model i_host (
        .ref_clk (ref_clk),
        .cs_n    (cs_n),
        .sclk    (sclk),
        .mosi    (mosi),
        .miso    (miso),
        .miso_oe (miso_oe)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Pin and enable must both drop once the frame has closed
    task automatic check_idle();
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        check({miso_oe, miso}, 2'b00);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_header();
        i_host.xfer(8'h5a, 24'h000000, 24, 2);
        for (int i = 0; i < 24; i++) begin
            check(i_host.rx[i], hdr_exp[i]);
        end
        check({i_host.rx[0], i_host.rx[1], i_host.rx[2], i_host.rx[3]}, 32'h53464450);
        check({i_host.rx[4], i_host.rx[5], i_host.rx[6]}, 24'h060101);
        check(i_host.rx[11], 8'h10);
        check(i_host.rx[6] + 8'h01, 8'h02);
        check(i_host.oe_all, 1'b1);
        check_idle();
    endtask

    // Tables are found through the header, never at an assumed place
    task automatic test_pointers();
        i_host.xfer(8'h5a, 24'h00000b, 12, 6);
        ptr1 = {i_host.rx[3], i_host.rx[2], i_host.rx[1]};
        ptr2 = {i_host.rx[11], i_host.rx[10], i_host.rx[9]};
        check(ptr1, 24'h000300);
        check(ptr1 > 24'h00000f, 1'b1);
        check(ptr2 >= ptr1 + {i_host.rx[0], 2'b00}, 1'b1);
        // follow the pointer; body values are not relied on
        i_host.xfer(8'h5a, ptr2, 2, 2);
        check(i_host.oe_all, 1'b1);
        check_idle();
    endtask

    task automatic test_bad_cmd();
        logic [7:0] cmds [0:3];
        cmds = '{8'h03, 8'h0b, 8'h9f, 8'h5b};
        for (int i = 0; i < 4; i++) begin
            i_host.xfer(cmds[i], 24'h000000, 2, 2);
            check(i_host.oe_any, 1'b0);
        end
    endtask

    // A program-style frame aimed at the space must leave it as it was
    task automatic test_readonly();
        i_host.xfer(8'h02, 24'h000000, 4, 2);
        check(i_host.oe_any, 1'b0);
        i_host.xfer(8'h5a, 24'h000000, 1, 2);
        check(i_host.rx[0], 8'h53);
    endtask

    // Enable low freezes the block, so a whole frame passes unseen
    task automatic test_freeze();
        @(posedge ref_clk);
        ce <= 1'b0;
        i_host.xfer(8'h5a, 24'h000000, 2, 2);
        ce <= 1'b1;
        check(i_host.oe_any, 1'b0);
        i_host.xfer(8'h5a, 24'h000000, 1, 2);
        check(i_host.rx[0], SIG_S);
        check_idle();
    endtask

    // Short frame, reset between frames, then a start at a non-zero address
    task automatic test_abort_reset();
        i_host.xfer(8'h5a, 24'h000004, 1, 2);
        check(i_host.rx[0], 8'h06);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        check({miso_oe, miso}, 2'b00);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        i_host.xfer(8'h5a, 24'h000001, 3, 3);
        check({i_host.rx[0], i_host.rx[1], i_host.rx[2]}, 24'h464450);
        check_idle();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge ref_clk);
        mismatches++;
        results();
    end

    initial begin
        mismatches = 0;
        n_tests    = 0;
        rst_n      = 1'b0;
        ce         = 1'b1;
        hdr_exp    = '{SIG_S, SIG_F, SIG_D, SIG_P, 8'h06, 8'h01, 8'h01, 8'hff,
                       8'h00, 8'h06, 8'h01, 8'h10, 8'h00, 8'h03, 8'h00, 8'hff,
                       8'h84, 8'h00, 8'h01, 8'h02, 8'h40, 8'h03, 8'h00, 8'hff};
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        test_header();
        test_pointers();
        test_bad_cmd();
        test_readonly();
        test_freeze();
        test_abort_reset();
        results();
    end
endmodule
`default_nettype wire
